// ===== rtl/lcs_pkg.sv
/*
  Package of the LCD supply, port and interrupt-vector register bank:
  register offsets, field positions, write masks, vector codes, carriers
  and shared helper functions.
  Assumes a 32-bit classic Wishbone slave; each 16-bit register sits in
  the low half of one aligned word.
*/
package lcs_pkg;

  // Byte offsets of the register words
  localparam logic [7:0] ADR_CTL0 = 8'h00;
  localparam logic [7:0] ADR_CTL1 = 8'h04;
  localparam logic [7:0] ADR_VCTL = 8'h08;
  localparam logic [7:0] ADR_PCTL0 = 8'h0C;
  localparam logic [7:0] ADR_PCTL1 = 8'h10;
  localparam logic [7:0] ADR_PCTL2 = 8'h14;
  localparam logic [7:0] ADR_PCTL3 = 8'h18;
  localparam logic [7:0] ADR_CCP = 8'h1C;
  localparam logic [7:0] ADR_IV = 8'h20;

  // Reset value of every register
  localparam logic [15:0] REG_RST = 16'h0000;

  // Main control word fields
  localparam int C0_ON = 0;
  localparam int C0_MUX_LO = 3;
  localparam logic [15:0] C0_WMASK = 16'h0039;

  // Flag / enable word: flags in 3-0, enables in 11-8, same order
  localparam int FLG_FRM = 0;
  localparam int FLG_BOFF = 1;
  localparam int FLG_BON = 2;
  localparam int FLG_NOCAP = 3;
  localparam int C1_IE_LO = 8;
  localparam logic [15:0] C1_WMASK = 16'h0F0F;

  // Supply and bias control fields
  localparam int VC_HALF = 0;
  localparam int VC_REF_LO = 1;
  localparam int VC_PUMP = 3;
  localparam int VC_SUPEXT = 4;
  localparam int VC_EXTBIAS = 5;
  localparam int VC_V5PIN = 6;
  localparam int VC_BPINS = 7;
  localparam int VC_LVL_LO = 9;
  localparam logic [15:0] VC_WMASK = 16'h1EFF;

  // Pump control fields
  localparam int CP_SYNC = 15;
  localparam logic [15:0] CP_WMASK = 16'h80FF;

  // Reference select codes and mux rates
  localparam logic [1:0] REF_INT = 2'b00;
  localparam logic [1:0] REF_EXT = 2'b01;
  localparam logic [1:0] REF_PIN = 2'b10;
  localparam logic [1:0] REF_RSV = 2'b11;
  localparam logic [2:0] MUX_STATIC = 3'h0;
  localparam logic [2:0] MUX_5 = 3'h4;

  // Interrupt vector codes
  localparam logic [15:0] IV_NONE = 16'h0000;
  localparam logic [15:0] IV_NOCAP = 16'h0002;
  localparam logic [15:0] IV_BOFF = 16'h0004;
  localparam logic [15:0] IV_BON = 16'h0006;
  localparam logic [15:0] IV_FRM = 16'h0008;

  // Build options: segment count, shared commons, dedicated lines
  localparam int SEG_LINES = 54;
  localparam int SEG_MAX = 384;
  localparam logic COM_SHARED = 1'b1;
  localparam logic [63:0] DEDICATED = 64'h0000000000000000;

  // Decoded supply and bias state driven to the analogue side
  typedef struct packed {
    logic pump_run;
    logic supply_ext;
    logic ref_int;
    logic ref_ext;
    logic ref_pin;
    logic half_bias;
    logic ext_bias;
    logic bias_pins;
    logic v5_pin;
    logic [3:0] level;
  } lcs_supply_t;

  // Whole state of the register bank
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [3:0] iv_pick;
    logic [15:0] ctl0;
    logic [15:0] ctl1;
    logic [15:0] vctl;
    logic [3:0][15:0] pctl;
    logic [15:0] ccp;
  } lcs_state_t;

  // Byte-lane merge of a write, reserved bits forced to zero
  function automatic logic [15:0] lcs_merge(input logic [15:0] old,
      input logic [15:0] wd, input logic [1:0] sel, input logic [15:0] msk);
    logic [15:0] v;
    v[15:8] = sel[1] ? wd[15:8] : old[15:8];
    v[7:0] = sel[0] ? wd[7:0] : old[7:0];
    return v & msk;
  endfunction

  // Segment enables that exist for this build; the rest read as zero
  function automatic logic [63:0] lcs_seg_ok();
    logic [63:0] m;
    m = 64'h003FFFFFFFFFFFFF;
    case (SEG_MAX)
      192: m = COM_SHARED ? 64'h000000007FFFFFFF : 64'h0000000000FFFFFF;
      256: m = COM_SHARED ? 64'h0000007FFFFFFFFF : 64'h00000000FFFFFFFF;
      320: m = COM_SHARED ? 64'h00007FFFFFFFFFFF : 64'h000000FFFFFFFFFF;
      default: m = COM_SHARED ? 64'h003FFFFFFFFFFFFF : 64'h0000FFFFFFFFFFFF;
    endcase
    return m;
  endfunction

endpackage

// ===== rtl/lcs_irq_prio.sv
/*
  Priority encoder of the interrupt vector: picks the highest pending
  enabled source and gives its code and a one-hot pick.
  Assumes flag and enable bits in the order of the flag word.
*/
`timescale 1ns/1ns
module lcs_irq_prio
  import lcs_pkg::*;
(
  input wire logic [3:0] flag_i, // Sticky flags
  input wire logic [3:0] en_i, // Source enables
  output logic [15:0] vec_o, // Vector code
  output logic [3:0] pick_o // One-hot reported source
);

  logic [3:0] pend;

  // Pending means flag and enable together
  assign pend = flag_i & en_i;

  // No-capacitor first, frame last
  always_comb begin
    vec_o = IV_NONE;
    pick_o = 4'h0;
    if (pend[FLG_NOCAP]) begin
      vec_o = IV_NOCAP;
      pick_o[FLG_NOCAP] = 1'b1;
    end else if (pend[FLG_BOFF]) begin
      vec_o = IV_BOFF;
      pick_o[FLG_BOFF] = 1'b1;
    end else if (pend[FLG_BON]) begin
      vec_o = IV_BON;
      pick_o[FLG_BON] = 1'b1;
    end else if (pend[FLG_FRM]) begin
      vec_o = IV_FRM;
      pick_o[FLG_FRM] = 1'b1;
    end
  end

endmodule // lcs_irq_prio

// ===== rtl/lcs_regs.sv
/*
  LCD supply, segment-port and interrupt-vector register bank with a
  classic Wishbone slave. Decodes supply, reference, bias, pump and
  segment-pin function from the registers.
  Assumes synchronous event pulses from the waveform and blink logic and
  a display-memory write strobe from the memory block.
*/
// Contract
// - Supply source bit: 0 internal supply, 1 external supply.
// - Pump runs only if enabled, internal supply, and level or reference nonzero.
// - Reference code 00 internal, 01 external, 10 internal routed to pin.
// - Reference code 11 acts as external reference.
// - External bias or bias on pins forces internal reference.
// - Bias bit: 0 one-third, 1 one-half bias.
// - Static or five-mux and above ignore bias bit, use one-third.
// - Segment enable 0 gives pin to port, 1 to LCD.
// - Dedicated LCD pins are always LCD lines.
// - Four enable registers cover lines 0-53; upper bits of last read zero.
// - 192-segment builds reserve enable 31 or enables 24-31.
// - 256 and 320 builds reserve upper enables per common sharing.
// - Sync bit 15 syncs pump clock while clock enabled without fault.
// - Permit bit 1 lets its function stop the pump; 0 blocks it.
// - Vector reads 00, 02, 04, 06, 08 per source.
// - Highest-priority pending source reported; no-capacitor highest, frame lowest.
// - Vector register is read-only and reads zero after reset.
// - Module-on bit turns module off at 0, on at 1.
// - Mux rate 000 static, 001 to 111 two- to eight-mux.
// - No-capacitor flag sets when pump enabled and capacitor missing; the code sets it only while pump_run is high.
// - Blink and frame flags clear on display memory write.
`timescale 1ns/1ns
module lcs_regs
  import lcs_pkg::*;
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic nocap_detect_i, // Capacitor absent on pump pin
  input wire logic blink_off_evt_i, // Blink segments-off pulse
  input wire logic blink_on_evt_i, // Blink segments-on pulse
  input wire logic frame_evt_i, // Frame pulse
  input wire logic mem_wr_i, // Display memory write strobe
  input wire logic sync_clk_en_i, // Sync clock source running
  input wire logic sync_clk_fault_i, // Sync clock source fault
  input wire logic [7:0] pump_dis_req_i, // Functions asking pump off
  output logic module_on_o, // Whole module on
  output logic [2:0] mux_rate_o, // Mux rate code
  output lcs_supply_t supply_o, // Supply, reference, bias decode
  output logic pump_sync_o, // Pump clock synchronised
  output logic [SEG_LINES-1:0] seg_lcd_o // 1: pin is LCD segment
);

  lcs_state_t st_r, st_nxt;
  logic [63:0] seg_ok;
  logic [63:0] pctl_flat;
  logic [15:0] iv_vec;
  logic [3:0] iv_pick;
  logic [1:0] ref_sel;
  logic [2:0] mux;
  logic bias_override;
  logic pump_blocked;
  logic req_first;
  logic wr_fire;
  logic rd_fire;
  logic [15:0] rd_val;
  logic [3:0] fl;

  assign seg_ok = lcs_seg_ok();
  assign pctl_flat = st_r.pctl;
  assign mux = st_r.ctl0[C0_MUX_LO +: 3];
  assign ref_sel = st_r.vctl[VC_REF_LO +: 2];

  // Bus phases: first cycle captures read data, ack cycle commits
  assign req_first = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack;
  assign rd_fire = wb_cyc_i & wb_stb_i & ~wb_we_i & st_r.ack;

  lcs_irq_prio u_prio (
    .flag_i(st_r.ctl1[3:0]),
    .en_i(st_r.ctl1[C1_IE_LO +: 4]),
    .vec_o(iv_vec),
    .pick_o(iv_pick)
  );

  // Read multiplexer; unmapped words read zero
  always_comb begin
    rd_val = 16'h0000;
    case (wb_adr_i)
      ADR_CTL0: rd_val = st_r.ctl0;
      ADR_CTL1: rd_val = st_r.ctl1;
      ADR_VCTL: rd_val = st_r.vctl;
      ADR_PCTL0: rd_val = st_r.pctl[0];
      ADR_PCTL1: rd_val = st_r.pctl[1];
      ADR_PCTL2: rd_val = st_r.pctl[2];
      ADR_PCTL3: rd_val = st_r.pctl[3];
      ADR_CCP: rd_val = st_r.ccp;
      ADR_IV: rd_val = iv_vec;
      default: rd_val = 16'h0000;
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req_first;
    st_nxt.iv_pick = 4'h0;
    if (req_first) begin
      st_nxt.dat = {16'h0000, rd_val};
      // Latch the reported source so the ack edge clears that one
      if (!wb_we_i && wb_adr_i == ADR_IV) begin
        st_nxt.iv_pick = iv_pick;
      end
    end
    // Writes take effect only at the acknowledged edge
    if (wr_fire) begin
      case (wb_adr_i)
        ADR_CTL0: st_nxt.ctl0 = lcs_merge(st_r.ctl0, wb_dat_i[15:0], wb_sel_i[1:0],
            C0_WMASK);
        ADR_CTL1: st_nxt.ctl1 = lcs_merge(st_r.ctl1, wb_dat_i[15:0], wb_sel_i[1:0],
            C1_WMASK);
        ADR_VCTL: st_nxt.vctl = lcs_merge(st_r.vctl, wb_dat_i[15:0], wb_sel_i[1:0],
            VC_WMASK);
        // Missing enables stay zero for this build
        ADR_PCTL0: st_nxt.pctl[0] = lcs_merge(st_r.pctl[0], wb_dat_i[15:0],
            wb_sel_i[1:0], seg_ok[15:0]);
        ADR_PCTL1: st_nxt.pctl[1] = lcs_merge(st_r.pctl[1], wb_dat_i[15:0],
            wb_sel_i[1:0], seg_ok[31:16]);
        ADR_PCTL2: st_nxt.pctl[2] = lcs_merge(st_r.pctl[2], wb_dat_i[15:0],
            wb_sel_i[1:0], seg_ok[47:32]);
        ADR_PCTL3: st_nxt.pctl[3] = lcs_merge(st_r.pctl[3], wb_dat_i[15:0],
            wb_sel_i[1:0], seg_ok[63:48]);
        ADR_CCP: st_nxt.ccp = lcs_merge(st_r.ccp, wb_dat_i[15:0], wb_sel_i[1:0],
            CP_WMASK);
        default: st_nxt.ccp = st_r.ccp; // Vector and holes ignore writes
      endcase
    end
    // Flags: software value, then clears, then hardware sets win
    fl = st_nxt.ctl1[3:0];
    if (mem_wr_i) begin
      fl[FLG_FRM] = 1'b0;
      fl[FLG_BOFF] = 1'b0;
      fl[FLG_BON] = 1'b0;
    end
    if (rd_fire) begin
      fl = fl & ~st_r.iv_pick;
    end
    if (nocap_detect_i && supply_o.pump_run) begin
      fl[FLG_NOCAP] = 1'b1;
    end
    if (blink_off_evt_i) begin
      fl[FLG_BOFF] = 1'b1;
    end
    if (blink_on_evt_i) begin
      fl[FLG_BON] = 1'b1;
    end
    if (frame_evt_i) begin
      fl[FLG_FRM] = 1'b1;
    end
    st_nxt.ctl1[3:0] = fl;
  end

  // State register; every field resets to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;

  // Bias from pins or outside makes the reference selector moot
  assign bias_override = st_r.vctl[VC_EXTBIAS] | st_r.vctl[VC_BPINS];
  // Any permitted function may pull the pump down
  assign pump_blocked = |(pump_dis_req_i & st_r.ccp[7:0]);

  // Supply, reference and bias decode for the analogue side
  always_comb begin
    supply_o = '0;
    supply_o.supply_ext = st_r.vctl[VC_SUPEXT];
    supply_o.pump_run = st_r.vctl[VC_PUMP] & ~st_r.vctl[VC_SUPEXT] &
        ((st_r.vctl[VC_LVL_LO +: 4] != 4'h0) | (ref_sel != REF_INT)) &
        ~pump_blocked;
    if (bias_override) begin
      supply_o.ref_int = 1'b1;
    end else begin
      case (ref_sel)
        REF_INT: supply_o.ref_int = 1'b1;
        REF_EXT: supply_o.ref_ext = 1'b1;
        REF_PIN: begin
          supply_o.ref_int = 1'b1;
          supply_o.ref_pin = 1'b1;
        end
        REF_RSV: supply_o.ref_ext = 1'b1;
        default: supply_o.ref_int = 1'b1;
      endcase
    end
    // Static and five-mux or more force one-third bias
    supply_o.half_bias = st_r.vctl[VC_HALF] & (mux != MUX_STATIC) & (mux < MUX_5);
    supply_o.ext_bias = st_r.vctl[VC_EXTBIAS];
    supply_o.bias_pins = st_r.vctl[VC_BPINS] & ~st_r.vctl[VC_EXTBIAS];
    supply_o.v5_pin = st_r.vctl[VC_V5PIN];
    supply_o.level = st_r.vctl[VC_LVL_LO +: 4];
  end

  // Sync only while the chosen clock runs clean
  assign pump_sync_o = st_r.ccp[CP_SYNC] & sync_clk_en_i & ~sync_clk_fault_i;

  // Shared pins follow their enable, dedicated ones are always LCD
  assign seg_lcd_o = pctl_flat[SEG_LINES-1:0] | DEDICATED[SEG_LINES-1:0];

  assign module_on_o = st_r.ctl0[C0_ON];
  assign mux_rate_o = mux;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [7:0] a);
    wr_fire && wb_adr_i == a && wb_sel_i[1:0] == 2'b11;
  endsequence

  sequence s_iv_read;
    req_first && !wb_we_i && wb_adr_i == ADR_IV ##1 rd_fire;
  endsequence

  a_bus_ack: assert property (req_first |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");

  a_supply_sel: assert property (s_wr(ADR_VCTL) |=>
      supply_o.supply_ext == $past(wb_dat_i[VC_SUPEXT]))
    else $error("supply source does not follow write");

  a_pump_run_cond: assert property (wr_fire && wb_adr_i == ADR_VCTL &&
      wb_sel_i[1:0] == 2'b11 && wb_dat_i[VC_PUMP] && !wb_dat_i[VC_SUPEXT] &&
      wb_dat_i[VC_LVL_LO +: 4] != 4'h0 ##1 !pump_blocked |-> supply_o.pump_run)
    else $error("pump not running when enabled");

  a_ref_decode: assert property (!bias_override && ref_sel == REF_PIN
      |-> supply_o.ref_int && supply_o.ref_pin && !supply_o.ref_ext)
    else $error("pin reference decode wrong");

  a_ref_reserved: assert property (!bias_override && ref_sel == REF_RSV
      |-> supply_o.ref_ext && !supply_o.ref_int)
    else $error("reserved reference not external");

  a_ref_override: assert property (bias_override
      |-> supply_o.ref_int && !supply_o.ref_ext && !supply_o.ref_pin)
    else $error("reference not forced internal");

  a_bias_ignore: assert property ((mux == MUX_STATIC || mux >= MUX_5)
      |-> !supply_o.half_bias)
    else $error("half bias in static or high mux");

  a_seg_func: assert property (s_wr(ADR_PCTL0) |=>
      seg_lcd_o[15:0] == ($past(wb_dat_i[15:0]) & seg_ok[15:0] | DEDICATED[15:0]))
    else $error("segment function does not follow enable");

  a_seg_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_PCTL3
      |-> wb_dat_o[15:6] == 10'h000)
    else $error("reserved enable bits read nonzero");

  a_pump_sync: assert property (pump_sync_o
      |-> st_r.ccp[CP_SYNC] && sync_clk_en_i && !sync_clk_fault_i)
    else $error("pump sync without clean clock");

  a_pump_permit: assert property (|(pump_dis_req_i & st_r.ccp[7:0])
      |-> !supply_o.pump_run)
    else $error("permitted disable ignored");

  a_iv_prio: assert property (req_first && !wb_we_i && wb_adr_i == ADR_IV &&
      st_r.ctl1[FLG_NOCAP] && st_r.ctl1[C1_IE_LO + FLG_NOCAP] |=> wb_dat_o[15:0] == IV_NOCAP)
    else $error("vector not highest priority");

  a_iv_clear: assert property (s_iv_read ##0 (wb_dat_o[15:0] == IV_FRM &&
      !frame_evt_i) |=> !st_r.ctl1[FLG_FRM])
    else $error("read did not clear reported flag");

  a_nocap_set: assert property (nocap_detect_i && supply_o.pump_run
      |=> st_r.ctl1[FLG_NOCAP])
    else $error("no-capacitor flag not set");

  a_mem_clear: assert property (mem_wr_i && !frame_evt_i && !blink_on_evt_i &&
      !blink_off_evt_i && !(wr_fire && wb_adr_i == ADR_CTL1) |=> st_r.ctl1[2:0] == 3'h0)
    else $error("memory write did not clear flags");

  // Decode checks compare against the written value or the register bits, so a broken decode cannot hide
  a_half_bias_sel: assert property (s_wr(ADR_VCTL) ##1
      (mux != MUX_STATIC && mux < MUX_5) |-> supply_o.half_bias == $past(wb_dat_i[VC_HALF]))
    else $error("half bias does not follow bias bit");

  a_half_needs_bit: assert property (!st_r.vctl[VC_HALF] |-> !supply_o.half_bias)
    else $error("half bias without bias bit");

  a_pump_needs_en: assert property (!st_r.vctl[VC_PUMP] || st_r.vctl[VC_SUPEXT]
      |-> !supply_o.pump_run)
    else $error("pump runs while disabled or external");

  a_mux_rate: assert property (s_wr(ADR_CTL0) |=>
      mux_rate_o == $past(wb_dat_i[C0_MUX_LO +: 3]))
    else $error("mux rate does not follow write");

  a_module_on: assert property (s_wr(ADR_CTL0) |=>
      module_on_o == $past(wb_dat_i[C0_ON]))
    else $error("module on does not follow write");

  a_seg_upper: assert property (s_wr(ADR_PCTL1) |=>
      seg_lcd_o[31:16] == ($past(wb_dat_i[15:0]) & seg_ok[31:16] | DEDICATED[31:16]))
    else $error("upper segment function does not follow enable");

  a_seg_top_zero: assert property (st_r.pctl[3][15:6] == 10'h000)
    else $error("reserved enable bits hold ones");

  // Vector read paths: nothing pending, and frame as the only pending source
  a_iv_idle: assert property (req_first && !wb_we_i && wb_adr_i == ADR_IV &&
      (st_r.ctl1[3:0] & st_r.ctl1[C1_IE_LO +: 4]) == 4'h0 |=> wb_dat_o[15:0] == IV_NONE)
    else $error("vector reports a source that is not pending");

  a_iv_frame: assert property (req_first && !wb_we_i && wb_adr_i == ADR_IV &&
      (st_r.ctl1[3:0] & st_r.ctl1[C1_IE_LO +: 4]) == 4'h1 |=> wb_dat_o[15:0] == IV_FRM)
    else $error("frame source not reported as frame code");

  a_iv_no_write: assert property (wr_fire && wb_adr_i == ADR_IV |=>
      $stable(st_r.ctl0) && $stable(st_r.vctl) && $stable(st_r.pctl) && $stable(st_r.ccp))
    else $error("vector write changed a register");

  a_iv_after_reset: assert property ($fell(rst_i) |-> iv_vec == IV_NONE)
    else $error("vector not zero after reset");

endmodule // lcs_regs

// ===== verification/lcs_glass_model.sv
/*
  Behavioural model of the glass-side sources seen by the register bank:
  capacitor-missing sense, blink and frame events, display memory writes.
  Assumes the bench raises a request level and the model turns each rise
  into one clock-wide pulse, as the waveform and memory logic would.
*/
`timescale 1ns/1ns
module lcs_glass_model (
  input wire logic clk_i, // Bench clock
  input wire logic [3:0] fire_i, // Requests: nocap, blink on, blink off, frame
  input wire logic wipe_i, // Request one display memory write
  output logic [3:0] evt_o, // One-cycle pulses in flag-word order
  output logic mem_wr_o // One-cycle display memory write strobe
);
  logic [3:0] fire_q = 4'h0;
  logic wipe_q = 1'b0;

  // Edge detect: a held request still yields only one pulse; quiet from the first edge
  always @(posedge clk_i) begin
    fire_q <= fire_i;
    wipe_q <= wipe_i;
    evt_o <= fire_i & ~fire_q;
    mem_wr_o <= wipe_i & ~wipe_q;
  end
endmodule // lcs_glass_model

// ===== verification/tb.sv
/*
  Self-checking bench of the LCD supply, port and vector register bank.
  Assumes the event timing of the bank; bus tasks wait for ack, bounded.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb
  import lcs_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] fire = 4'h0;
  logic wipe = 1'b0;
  logic [3:0] evt;
  logic mem_wr;
  logic sync_en = 1'b0;
  logic sync_fault = 1'b0;
  logic [7:0] dis_req = 8'h00;
  logic module_on_o;
  logic [2:0] mux_rate_o;
  lcs_supply_t supply_o;
  logic pump_sync_o;
  logic [SEG_LINES-1:0] seg_lcd_o;
  logic [15:0] q;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] adrs [10] = '{ADR_CTL0, ADR_CTL1, ADR_VCTL, ADR_PCTL0, ADR_PCTL1,
    ADR_PCTL2, ADR_PCTL3, ADR_CCP, ADR_IV, 8'h24};
  logic [15:0] ivs [5] = '{IV_NOCAP, IV_BOFF, IV_BON, IV_FRM, IV_NONE};

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  lcs_regs i_lcs_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .nocap_detect_i(evt[3]), .blink_off_evt_i(evt[1]),
    .blink_on_evt_i(evt[2]), .frame_evt_i(evt[0]), .mem_wr_i(mem_wr),
    .sync_clk_en_i(sync_en), .sync_clk_fault_i(sync_fault), .pump_dis_req_i(dis_req),
    .module_on_o(module_on_o), .mux_rate_o(mux_rate_o), .supply_o(supply_o),
    .pump_sync_o(pump_sync_o), .seg_lcd_o(seg_lcd_o));

  lcs_glass_model i_lcs_glass_model (.clk_i(clk_i), .fire_i(fire), .wipe_i(wipe),
    .evt_o(evt), .mem_wr_o(mem_wr));

  // Verdict and the single end of the run
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    q = wb_dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
    @(negedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    `CHK(q, e)
  endtask

  // Event requests; the model pulses one cycle later and the flag lands after it
  task automatic pulse(input logic [3:0] f, input logic w);
    @(posedge clk_i);
    fire <= f;
    wipe <= w;
    @(posedge clk_i);
    fire <= 4'h0;
    wipe <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic set_in(input logic [7:0] d, input logic e, input logic f);
    @(posedge clk_i);
    dis_req <= d;
    sync_en <= e;
    sync_fault <= f;
    @(negedge clk_i);
  endtask

  task automatic tdone(input string s);
    $display("test %s done, miscompares so far %0d", s, miscompares);
  endtask

  // Main sequence; settings change only with the module off
  initial begin
    logic forced;
    logic [15:0] b;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i]) rd(adrs[i], REG_RST);
    wr(ADR_IV, 16'hFFFF);
    rd(ADR_IV, IV_NONE);
    wr(ADR_VCTL, 16'hFFFF);
    `CHK(supply_o, {1'b0, 1'b1, 1'b1, 3'b000, 1'b1, 1'b0, 1'b1, 4'hF})
    rd(ADR_VCTL, VC_WMASK);
    wr(ADR_PCTL3, 16'hFFFF);
    rd(ADR_PCTL3, 16'h003F);
    wr(ADR_CCP, 16'hFFFF);
    rd(ADR_CCP, CP_WMASK);
    tdone("reset");
    wr(ADR_PCTL0, 16'hA5C3);
    wr(ADR_PCTL1, 16'h3C96);
    wr(ADR_PCTL2, 16'h0FF0);
    `CHK(seg_lcd_o, 54'h3F0FF03C96A5C3)
    tdone("segments");
    wr(ADR_CCP, 16'h0000);
    wr(ADR_VCTL, 16'h0018);
    `CHK(supply_o.supply_ext, 1'b1)
    `CHK(supply_o.pump_run, 1'b0)
    wr(ADR_VCTL, 16'h0008);
    `CHK(supply_o.pump_run, 1'b0)
    wr(ADR_VCTL, 16'h0208);
    `CHK(supply_o.pump_run, 1'b1)
    `CHK(supply_o.level, 4'h1)
    `CHK(supply_o.supply_ext, 1'b0)
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0020 : 16'h0080;
      forced = (k != 0);
      for (int r = 0; r < 4; r++) begin
        wr(ADR_VCTL, b | 16'(r << 1));
        `CHK(supply_o.ref_ext, !forced && r[0])
        `CHK(supply_o.ref_pin, !forced && r == 2)
        `CHK(supply_o.ref_int, forced || r == 0 || r == 2)
        `CHK(supply_o.ext_bias, k == 1)
        `CHK(supply_o.bias_pins, k == 2)
      end
    end
    tdone("supply");
    for (int m = 0; m < 8; m++) begin
      wr(ADR_CTL0, 16'(m << 3));
      wr(ADR_VCTL, 16'h0001);
      `CHK(mux_rate_o, m[2:0])
      `CHK(supply_o.half_bias, m >= 1 && m <= 3)
    end
    wr(ADR_VCTL, 16'h0000);
    `CHK(supply_o.half_bias, 1'b0)
    wr(ADR_CTL0, 16'h0001);
    `CHK(module_on_o, 1'b1)
    wr(ADR_CTL0, 16'h0000);
    `CHK(module_on_o, 1'b0)
    tdone("bias");
    wr(ADR_CCP, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      set_in(8'h00, i[0], i[1]);
      `CHK(pump_sync_o, i[0] & ~i[1])
    end
    wr(ADR_VCTL, 16'h0208);
    wr(ADR_CCP, 16'h0001);
    set_in(8'h02, 1'b1, 1'b0);
    `CHK(pump_sync_o, 1'b0)
    `CHK(supply_o.pump_run, 1'b1)
    set_in(8'h01, 1'b1, 1'b0);
    `CHK(supply_o.pump_run, 1'b0)
    wr(ADR_CCP, 16'h0000);
    `CHK(supply_o.pump_run, 1'b1)
    set_in(8'h00, 1'b0, 1'b0);
    tdone("pump");
    wr(ADR_VCTL, 16'h0000);
    wr(ADR_CTL1, 16'h0F00);
    pulse(4'h8, 1'b0);
    rd(ADR_CTL1, 16'h0F00);
    wr(ADR_VCTL, 16'h0208);
    pulse(4'hF, 1'b0);
    rd(ADR_CTL1, 16'h0F0F);
    foreach (ivs[i]) rd(ADR_IV, ivs[i]);
    pulse(4'h7, 1'b0);
    rd(ADR_CTL1, 16'h0F07);
    pulse(4'h0, 1'b1);
    rd(ADR_CTL1, 16'h0F00);
    wr(ADR_CTL1, 16'h0001);
    rd(ADR_IV, IV_NONE);
    wr(ADR_CTL1, 16'h0101);
    rd(ADR_IV, IV_FRM);
    rd(ADR_CTL1, 16'h0100);
    tdone("vector");
    end_sim();
  end
endmodule // tb
